// ==== core/flash_if_pkg.sv ====
// Constants and types for the serial flash interface state machine
// Overview of operation
// RULE_01: Chip select high: standby, ignore inputs
// RULE_02: Chip select falls: enter instruction cycles
// RULE_03: Capture eight instruction bits, MSB first
// RULE_04: Write-protect sampled only in register write
// RULE_05: Instruction picks address space and format
// RULE_06: Standalone command ends when chip select rises
// RULE_07: Pause pin freezes command when quad off
// RULE_08: Pause ignores inputs, floats outputs
// RULE_09: Pause release resumes the same state
// RULE_10: Quad mode: pause pin is data three
// RULE_11: DDR commands ignore pause and write-protect
// RULE_12: Single input uses line zero, output undriven
// RULE_13: Latency count from latency code field
// RULE_14: Latency cycles discard input, drive nothing
// RULE_15: Host releases lines by last latency
// RULE_16: Single output streams until chip select rises
// RULE_17: Dual I/O address two bits per clock
// RULE_18: Dual output two bits per clock
// RULE_19: Quad program/read address on line zero
// RULE_20: Address then quad input, latency or output
// RULE_21: Quad input four bits per clock
// RULE_22: Quad latency then quad output, undriven
// RULE_23: Quad output four bits per clock
// RULE_24: Quad enable permits quad commands only
// RULE_25: Output data changes after falling clock
package flash_if_pkg;

  // --------------------------------------------------------------
  // Instruction codes (decode table of this block)
  // --------------------------------------------------------------
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] OP_READ           = 8'h03;
  localparam logic [7:0] OP_DUAL_OUT_READ  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ   = 8'hEB;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;

  // --------------------------------------------------------------
  // Field positions and widths
  // --------------------------------------------------------------
  localparam int INSTR_BITS = 8;
  localparam int BYTE_BITS  = 8;
  localparam int IO_SI      = 0;
  localparam int IO_SO      = 1;
  localparam int IO_WP      = 2;
  localparam int IO_HOLD    = 3;
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;

  // Latency cycles selected by each latency code
  localparam logic [3:0] LAT_CODE0 = 4'h8;
  localparam logic [3:0] LAT_CODE1 = 4'h4;
  localparam logic [3:0] LAT_CODE2 = 4'h2;
  localparam logic [3:0] LAT_CODE3 = 4'h0;

  // --------------------------------------------------------------
  // Interface states and transfer formats
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STANDBY, ST_INSTR, ST_SIN_ADDR, ST_DIN_ADDR, ST_QIN_ADDR,
    ST_SIN_DATA, ST_QIN_DATA, ST_LATENCY, ST_SOUT, ST_DOUT, ST_QOUT,
    ST_DONE
  } if_state_t;

  typedef enum logic [2:0] {
    FMT_NONE, FMT_WREG, FMT_READ, FMT_DOR, FMT_DIO, FMT_QOR, FMT_QIO,
    FMT_QPP
  } fmt_t;

endpackage

// ==== core/flash_if_sm.sv ====
// Serial flash SPI interface state machine, device side
`timescale 1ns/1ns
`default_nettype none
module flash_if_sm
  import flash_if_pkg::*;
#(
  parameter int ADDR_BITS = 24
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 cs_n,
  input  wire logic                 sck,
  input  wire logic [3:0]           io_in,
  input  wire logic                 reset_n,
  input  wire logic                 quad_enable_bit,
  input  wire logic [1:0]           latency_code_field,
  input  wire logic [7:0]           rd_data,
  output logic      [3:0]           io_out,
  output logic      [3:0]           io_oe,
  output logic      [7:0]           instr_code,
  output logic                      instr_done,
  output logic      [ADDR_BITS-1:0] addr,
  output logic                      addr_done,
  output logic      [7:0]           wr_byte,
  output logic                      wr_byte_valid,
  output logic                      wp_level,
  output logic                      rd_take,
  output logic                      paused,
  output if_state_t                 if_state
);

  // --------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------
  // Quad formats are refused unless quad mode is on
  function automatic fmt_t decode(input logic [7:0] op, input logic qe);
    case (op)
      OP_REGISTER_WRITE: decode = FMT_WREG;
      OP_READ:           decode = FMT_READ;
      OP_DUAL_OUT_READ:  decode = FMT_DOR;
      OP_DUAL_IO_READ:   decode = FMT_DIO;
      OP_QUAD_OUT_READ:  decode = qe ? FMT_QOR : FMT_NONE; // RULE_24
      OP_QUAD_IO_READ:   decode = qe ? FMT_QIO : FMT_NONE; // RULE_24
      OP_QUAD_PAGE_PROG: decode = qe ? FMT_QPP : FMT_NONE; // RULE_24
      default:           decode = FMT_NONE;
    endcase
  endfunction

  function automatic logic [3:0] lat_cycles(input logic [1:0] code);
    case (code)
      2'd0:    lat_cycles = LAT_CODE0;
      2'd1:    lat_cycles = LAT_CODE1;
      2'd2:    lat_cycles = LAT_CODE2;
      default: lat_cycles = LAT_CODE3;
    endcase
  endfunction

  function automatic if_state_t out_state(input fmt_t f);
    case (f)
      FMT_DOR, FMT_DIO: out_state = ST_DOUT;
      FMT_QOR, FMT_QIO: out_state = ST_QOUT;
      default:          out_state = ST_SOUT;
    endcase
  endfunction

  // --------------------------------------------------------------
  // State record
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           cs_s;
    logic [2:0]           sck_s;
    logic [1:0]           rstn_s;
    logic [3:0]           io_s1;
    logic [3:0]           io_s2;
    if_state_t            state;
    fmt_t                 fmt;
    logic [7:0]           instr;
    logic [6:0]           cnt;
    logic [3:0]           lat;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0]           wbyte;
    logic [7:0]           sr;
    logic [3:0]           ocnt;
    logic                 started;
    logic [3:0]           io_out;
    logic [3:0]           oe;
    logic                 instr_done;
    logic                 addr_done;
    logic                 wr_valid;
    logic                 wp;
    logic                 rd_take;
    logic                 paused;
  } st_t;

  st_t q;
  st_t d;

  logic                 sck_rise;
  logic                 sck_fall;
  logic                 cs_hi;
  logic                 hold_act;
  logic [7:0]           op_new;
  logic [6:0]           cnt_new;
  logic [ADDR_BITS-1:0] addr_new;
  logic [3:0]           width;
  logic [7:0]           cur;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  // Pins are synchronised first; the second stage is looked at, and for the link clock the third stage too to find edges
  always_comb
  begin
    d          = q;
    d.cs_s     = {q.cs_s[1:0], cs_n};
    d.sck_s    = {q.sck_s[1:0], sck};
    d.rstn_s   = {q.rstn_s[0], reset_n};
    d.io_s1    = io_in;
    d.io_s2    = q.io_s1;
    d.instr_done = 1'b0;
    d.addr_done  = 1'b0;
    d.wr_valid   = 1'b0;
    d.rd_take    = 1'b0;
    d.paused     = 1'b0;
    sck_rise = q.sck_s[1] & ~q.sck_s[2];
    sck_fall = ~q.sck_s[1] & q.sck_s[2];
    cs_hi    = q.cs_s[1];
    // No DDR format is decoded, so only quad mode exempts the pause pin
    hold_act = ~quad_enable_bit & ~q.io_s2[IO_HOLD]; // RULE_07 RULE_10 RULE_11
    op_new   = {q.instr[6:0], q.io_s2[IO_SI]};
    cnt_new  = q.cnt;
    addr_new = q.addr;
    width    = 4'd1;
    cur      = (q.ocnt == 4'd0) ? rd_data : q.sr;
    if (!q.rstn_s[1] || cs_hi)
    begin
      // Standby: every input but chip select and the reset pin is ignored
      d.state   = ST_STANDBY; // RULE_01 RULE_06 RULE_16 RULE_21
      d.started = 1'b0;
      d.ocnt    = 4'd0;
    end
    else if (hold_act && q.state != ST_STANDBY)
    begin
      // Clock edges are dropped, so progress is simply frozen
      d.paused = 1'b1; // RULE_07 RULE_08 RULE_09
    end
    else
    begin
      case (q.state)
        ST_STANDBY:
        begin
          d.state = ST_INSTR; // RULE_02
          d.cnt   = '0;
          d.instr = '0;
        end
        ST_INSTR:
        begin
          if (sck_rise)
          begin
            d.instr = op_new; // RULE_03
            d.cnt   = q.cnt + 7'd1;
            if (q.cnt == 7'(INSTR_BITS - 1))
            begin
              d.instr_done = 1'b1;
              d.cnt        = '0;
              d.addr       = '0;
              d.fmt        = decode(op_new, quad_enable_bit); // RULE_05
              d.lat        = lat_cycles(latency_code_field); // RULE_13
              case (decode(op_new, quad_enable_bit))
                FMT_WREG:
                begin
                  d.state = ST_SIN_DATA;
                  d.wp    = q.io_s2[IO_WP]; // RULE_04
                end
                FMT_READ, FMT_DOR, FMT_QOR, FMT_QPP: d.state = ST_SIN_ADDR;
                FMT_DIO:  d.state = ST_DIN_ADDR;
                FMT_QIO:  d.state = ST_QIN_ADDR;
                default:  d.state = ST_DONE; // RULE_06
              endcase
            end
          end
        end
        ST_SIN_ADDR, ST_DIN_ADDR, ST_QIN_ADDR:
        begin
          if (sck_rise)
          begin
            // Line zero only for single; higher lines are don't-care
            case (q.state)
              ST_DIN_ADDR:
              begin
                width    = 4'd2; // RULE_17
                addr_new = {q.addr[ADDR_BITS-3:0], q.io_s2[1:0]};
              end
              ST_QIN_ADDR:
              begin
                width    = 4'd4; // RULE_21
                addr_new = {q.addr[ADDR_BITS-5:0], q.io_s2};
              end
              default:
              begin
                width    = 4'd1; // RULE_12 RULE_19
                addr_new = {q.addr[ADDR_BITS-2:0], q.io_s2[IO_SI]};
              end
            endcase
            cnt_new = q.cnt + 7'(width);
            d.addr  = addr_new;
            d.cnt   = cnt_new;
            if (cnt_new == 7'(ADDR_BITS))
            begin
              d.addr_done = 1'b1;
              d.cnt       = '0;
              if (q.fmt == FMT_QPP)
                d.state = ST_QIN_DATA; // RULE_20
              else if (q.lat == 4'd0)
                d.state = out_state(q.fmt); // RULE_17 RULE_20
              else
                d.state = ST_LATENCY;
            end
          end
        end
        ST_SIN_DATA, ST_QIN_DATA:
        begin
          if (sck_rise)
          begin
            if (q.state == ST_QIN_DATA)
            begin
              width   = 4'd4; // RULE_21
              d.wbyte = {q.wbyte[3:0], q.io_s2};
            end
            else
            begin
              width   = 4'd1;
              d.wbyte = {q.wbyte[6:0], q.io_s2[IO_SI]}; // RULE_12
            end
            cnt_new = q.cnt + 7'(width);
            d.cnt   = cnt_new;
            if (cnt_new == 7'(BYTE_BITS))
            begin
              d.wr_valid = 1'b1;
              d.cnt      = '0;
            end
          end
        end
        ST_LATENCY:
        begin
          // Line levels are not looked at while waiting
          if (sck_rise)
          begin
            d.cnt = q.cnt + 7'd1; // RULE_14 RULE_22
            if (q.cnt == 7'(q.lat - 4'd1))
              d.state = out_state(q.fmt); // RULE_22
          end
        end
        ST_SOUT, ST_DOUT, ST_QOUT:
        begin
          // Data moves on the falling edge so it is stable at the rise
          if (sck_fall)
          begin
            d.started = 1'b1; // RULE_25
            d.rd_take = (q.ocnt == 4'd0);
            case (q.state)
              ST_SOUT:
              begin
                width    = 4'd1;
                d.io_out = {2'b00, cur[7], 1'b0}; // RULE_16
              end
              ST_DOUT:
              begin
                width    = 4'd2;
                d.io_out = {2'b00, cur[7:6]}; // RULE_18
              end
              default:
              begin
                width    = 4'd4;
                d.io_out = cur[7:4]; // RULE_23
              end
            endcase
            d.sr   = cur << width;
            d.ocnt = ((q.ocnt == 4'd0) ? 4'(BYTE_BITS) : q.ocnt) - width;
          end
        end
        ST_DONE: d.state = ST_DONE;
        default: d.state = ST_STANDBY;
      endcase
    end
    // Drivers follow the state; released in any pause
    d.oe = OE_NONE; // RULE_08 RULE_14 RULE_15
    if (!d.paused && d.started)
    begin
      case (d.state)
        ST_SOUT: d.oe = OE_SINGLE;
        ST_DOUT: d.oe = OE_DUAL;
        ST_QOUT: d.oe = OE_QUAD;
        default: d.oe = OE_NONE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q        <= '0;
      q.cs_s   <= 3'b111;
      q.rstn_s <= 2'b11;
      q.state  <= ST_STANDBY;
      q.fmt    <= FMT_NONE;
    end
    else
      q <= d;
  end

  // Outputs straight from the state record
  assign io_out        = q.io_out;
  assign io_oe         = q.oe;
  assign instr_code    = q.instr;
  assign instr_done    = q.instr_done;
  assign addr          = q.addr;
  assign addr_done     = q.addr_done;
  assign wr_byte       = q.wbyte;
  assign wr_byte_valid = q.wr_valid;
  assign wp_level      = q.wp;
  assign rd_take       = q.rd_take;
  assign paused        = q.paused;
  assign if_state      = q.state;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_standby_on_cs: assert property (q.cs_s[1] && q.rstn_s[1] |=> // RULE_01
    q.state == ST_STANDBY && q.oe == OE_NONE)
    else $error("chip select high did not force standby");
  a_instr_entry: assert property (q.state == ST_STANDBY && !q.cs_s[1] // RULE_02
    && q.rstn_s[1] |=> q.state == ST_INSTR)
    else $error("chip select low did not start instruction");
  a_instr_eighth: assert property (q.instr_done |-> // RULE_03
    $past(q.cnt) == 7'(INSTR_BITS - 1) && $past(q.state) == ST_INSTR)
    else $error("instruction ended on wrong bit count");
  a_wp_only_wrr: assert property ($changed(q.wp) |-> // RULE_04
    q.instr_done && q.fmt == FMT_WREG)
    else $error("write-protect sampled outside register write");
  a_pause_floats: assert property (q.paused |-> q.oe == OE_NONE) // RULE_08
    else $error("lines driven during pause");
  // Only while the pin is still low; the cycle of release may take an edge
  a_pause_holds: assert property (q.paused && hold_act && !q.cs_s[1] && q.rstn_s[1] // RULE_09
    |=> $stable(q.state) && $stable(q.cnt))
    else $error("state moved during pause");
  a_quad_no_pause: assert property ($past(quad_enable_bit) |-> !q.paused) // RULE_10
    else $error("pause active in quad mode");
  a_input_undriven: assert property (q.state inside {ST_SIN_ADDR, // RULE_12
    ST_DIN_ADDR, ST_QIN_ADDR, ST_SIN_DATA, ST_QIN_DATA, ST_LATENCY}
    |-> q.oe == OE_NONE)
    else $error("line driven in input or latency phase");
  a_out_widths: assert property (q.oe != OE_NONE |-> // RULE_16
    (q.state == ST_SOUT && q.oe == OE_SINGLE) ||
    (q.state == ST_DOUT && q.oe == OE_DUAL) ||
    (q.state == ST_QOUT && q.oe == OE_QUAD))
    else $error("output enable does not match width");
  a_drive_on_fall: assert property ($changed(q.io_out) |-> // RULE_25
    $past(q.sck_s[2]) && !$past(q.sck_s[1]))
    else $error("output data changed off a falling edge");

endmodule // flash_if_sm
`default_nettype wire

// ==== dv/spi_host_model.sv ====
// Host SPI controller model: chip select, link clock and data lines
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] io_line,
  output var  logic       cs_n,
  output var  logic       sck,
  output var  logic [3:0] host_d,
  output var  logic [3:0] host_en
);
  // ------------------------------------------------
  // Idle: deselected, link clock parked low
  // ------------------------------------------------
  initial
  begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    host_d  = 4'h0;
    host_en = 4'h0;
  end

  // Line drive; every caller acts 1 ns after a system clock edge
  task automatic set(input logic [3:0] d, input logic [3:0] en);
    host_d  = d;
    host_en = en;
  endtask

  // Deselect also lets go of every line, so nothing lingers
  task automatic csel(input logic v);
    cs_n = v;
    if (v)
      host_en = 4'h0;
  endtask

  // One 400 ns link clock: data set while low, held until the fall
  task automatic clk(input logic [3:0] d, input logic [3:0] en, output logic [3:0] s);
    set(d, en);
    repeat (4) @(posedge sys_clk);
    #1 sck = 1'b1;
    s = io_line;
    repeat (4) @(posedge sys_clk);
    #1 sck = 1'b0;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== dv/serial_flash_sdr_interface_states_tb.sv ====
// Self-checking bench for the flash interface state machine
`timescale 1ns/1ns
`default_nettype none
module serial_flash_sdr_interface_states_tb;
  import flash_if_pkg::*;
  // ------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------
  logic sys_clk = 1'b0, rst, reset_n, quad_enable_bit, flt = 1'b0;
  logic [1:0] latency_code_field;
  logic [7:0] rd_data, ic;
  logic [3:0] io_out, io_oe, host_d, host_en, s;
  logic cs_n, sck, instr_done, addr_done, wr_byte_valid, wp_level, rd_take, paused;
  logic [7:0] instr_code, wr_byte;
  logic [23:0] addr, ac;
  if_state_t if_state;
  logic qe, wp, wexp = 1'b0, pz;
  logic [15:0] seed = 16'h0046;
  int k, pp, miscompares = 0, n_checks = 0;
  logic [7:0] rq[$], wq[$], xq[$];
  // Undriven lines show a pattern that flips every cycle
  wire logic [3:0] io_line = (io_oe & io_out) | (~io_oe & host_en & host_d)
                           | (~io_oe & ~host_en & {flt, ~flt, flt, ~flt});

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) flt <= ~flt;

  spi_host_model host (.sys_clk(sys_clk), .io_line(io_line), .cs_n(cs_n), .sck(sck),
                       .host_d(host_d), .host_en(host_en));

  flash_if_sm #(.ADDR_BITS(24)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_line),
    .reset_n(reset_n), .quad_enable_bit(quad_enable_bit),
    .latency_code_field(latency_code_field), .rd_data(rd_data), .io_out(io_out),
    .io_oe(io_oe), .instr_code(instr_code), .instr_done(instr_done), .addr(addr),
    .addr_done(addr_done), .wr_byte(wr_byte), .wr_byte_valid(wr_byte_valid),
    .wp_level(wp_level), .rd_take(rd_take), .paused(paused), .if_state(if_state));

  // ------------------------------------------------
  // Helpers: random source, compare, closing report
  // ------------------------------------------------
  function automatic logic [15:0] lf();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
    n_checks++;
    if (sn !== ex)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Record what the design hands over; fresh array byte after each take
  always @(posedge sys_clk)
  begin
    if (instr_done) ic = instr_code;
    if (addr_done) ac = addr;
    if (wr_byte_valid) wq.push_back(wr_byte);
    if (paused) pz = 1'b1;
    if (rd_take)
    begin
      rq.push_back(rd_data);
      #1 rd_data = 8'(lf());
    end
  end

  // One link clock of w host bits; with quad off, pause pin pulled low at clock pp
  task automatic one(input int w, input logic [3:0] c, output logic [3:0] sv);
    logic [3:0] d, en;
    begin
      d  = qe ? c : {1'b1, wp, c[1:0]};
      en = 4'((1 << w) - 1) | (qe ? 4'h0 : 4'hC);
      k++;
      if (k == pp && !qe)
      begin
        // Let the last fall through first, so no link edge meets the pin change
        cyc(4);
        host.set(d & 4'h7, en);
        cyc(6);
        chk("pause_flag", paused, 1);
        chk("pause_oe", io_oe, OE_NONE);
        host.clk(d & 4'h7, en, sv);
        host.clk(d & 4'h7, en, sv);
        cyc(4);
        host.set(d, en);
        cyc(6);
        chk("pause_end", paused, 0);
      end
      host.clk(d, en, sv);
    end
  endtask

  // Whole command: opcode, address, then write data, or latency then read data
  task automatic cmd(input logic [7:0] op, input int aw, input int na, input int lc,
                     input int dw, input int nb, input logic [3:0] ox, input logic q,
                     input int p);
    logic [23:0] a;
    logic [7:0] b;
    logic [3:0] sv;
    int lat;
    logic wr;
    begin
      a = 24'({lf(), lf()});
      wp = a[0];
      wr = (op == OP_REGISTER_WRITE) || (op == OP_QUAD_PAGE_PROG);
      lat = lc == 0 ? LAT_CODE0 : lc == 1 ? LAT_CODE1 : lc == 2 ? LAT_CODE2 : LAT_CODE3;
      qe = q;
      quad_enable_bit = q;
      latency_code_field = 2'(lc);
      pp = p;
      k = 0;
      pz = 1'b0;
      rq.delete();
      wq.delete();
      xq.delete();
      // Pause pin held high before select, or a floating level pauses the opcode
      host.set(4'h8, qe ? 4'h0 : 4'h8);
      host.csel(1'b0);
      cyc(4);
      for (int i = 0; i < 8; i++)
        one(1, 4'(op[7-i]), sv);
      for (int i = 0; i < na / aw; i++)
      begin
        one(aw, 4'((a >> (na - aw * (i + 1))) & ((1 << aw) - 1)), sv);
        chk("addr_oe", io_oe, OE_NONE);
      end
      for (int j = 0; wr && j < nb; j++)
      begin
        b = 8'(lf());
        xq.push_back(b);
        for (int i = 0; i < 8 / dw; i++)
          one(dw, 4'((b >> (8 - dw * (i + 1))) & ((1 << dw) - 1)), sv);
      end
      for (int i = 0; !wr && i < lat; i++)
      begin
        one(0, 4'h0, sv);
        chk("latency_oe", io_oe, OE_NONE);
      end
      for (int j = 0; !wr && j < nb; j++)
      begin
        b = 8'h00;
        for (int i = 0; i < 8 / dw; i++)
        begin
          one(0, 4'h0, sv);
          chk("out_oe", io_oe, ox);
          b = 8'((b << dw) | (dw == 1 ? 4'(sv[1]) : sv & 4'((1 << dw) - 1)));
        end
        if (ox !== OE_NONE)
          chk("read_byte", b, rq.pop_front());
      end
      if (!wr && ox === OE_NONE)
        chk("refused_state", if_state, ST_DONE);
      host.csel(1'b1);
      cyc(5);
      chk("idle_state", if_state, ST_STANDBY);
      chk("idle_oe", io_oe, OE_NONE);
      chk("opcode", ic, op);
      if (na > 0 && (wr || ox !== OE_NONE))
        chk("address", ac, a);
      chk("write_count", wq.size(), xq.size());
      while (xq.size() > 0)
        chk("write_byte", wq.pop_front(), xq.pop_front());
      if (op == OP_REGISTER_WRITE)
        wexp = wp;
      chk("wp_level", wp_level, wexp);
      chk("pause_seen", pz, p >= 0 && !q);
      $display("test opcode %h done", op);
    end
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reset_n = 1'b1;
    quad_enable_bit = 1'b0;
    latency_code_field = 2'h0;
    rd_data = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    cyc(4);
    chk("reset_state", if_state, ST_STANDBY);
    host.clk(4'h5, 4'hF, s);
    host.clk(4'hA, 4'hF, s);
    chk("standby_state", if_state, ST_STANDBY);
    cmd(OP_READ, 1, 24, 3, 1, 3, OE_SINGLE, 1'b0, -1);
    cmd(OP_READ, 1, 24, 2, 1, 2, OE_SINGLE, 1'b0, 20);
    cmd(OP_READ, 1, 24, 1, 1, 2, OE_SINGLE, 1'b0, 40);
    cmd(OP_DUAL_OUT_READ, 1, 24, 2, 2, 2, OE_DUAL, 1'b0, -1);
    cmd(OP_DUAL_IO_READ, 2, 24, 1, 2, 2, OE_DUAL, 1'b0, -1);
    cmd(OP_QUAD_OUT_READ, 1, 24, 0, 4, 2, OE_QUAD, 1'b1, -1);
    cmd(OP_QUAD_IO_READ, 4, 24, 3, 4, 2, OE_QUAD, 1'b1, 5);
    cmd(OP_QUAD_PAGE_PROG, 1, 24, 3, 4, 3, OE_NONE, 1'b1, -1);
    cmd(OP_REGISTER_WRITE, 1, 0, 3, 1, 1, OE_NONE, 1'b0, 3);
    cmd(OP_QUAD_OUT_READ, 1, 24, 3, 4, 1, OE_NONE, 1'b0, -1);
    cmd(8'h06, 1, 0, 3, 1, 0, OE_NONE, 1'b0, -1);
    // Hardware reset pin in mid-instruction forces standby
    host.set(4'h8, 4'h8);
    host.csel(1'b0);
    cyc(4);
    for (int i = 0; i < 4; i++)
      host.clk(4'h9, 4'hD, s);
    reset_n = 1'b0;
    cyc(5);
    chk("hw_reset_state", if_state, ST_STANDBY);
    reset_n = 1'b1;
    host.csel(1'b1);
    cyc(5);
    $display("test hardware reset done");
    cmd(OP_READ, 1, 24, 3, 1, 1, OE_SINGLE, 1'b0, -1);
    tally_and_finish;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish;
  end
endmodule // serial_flash_sdr_interface_states_tb
`default_nettype wire
